// ===== sdc_top.sv
// Purpose: Stall detection configuration, flag handling and emf sample timing
// Assumes: Back-emf value in millivolts arrives already measured; one clock
// Notes: Average tracked as a simple first-order filter of samples
//
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
module sdc_top
  import sdc_pkg::*;
#(
  parameter int EMF_W = 14,
  parameter int POS_W = 16
)
(
  input wire logic mclk,                        // 40 MHz clock
  input wire logic rst,                         // Synchronous reset, high
  input wire logic por,                         // Power-on reset pulse
  input wire logic [3:0] addr,                  // Register word address
  input wire logic [31:0] wdata,                // Write data
  input wire logic wr,                          // Write strobe
  input wire logic rd,                          // Read strobe
  output logic [31:0] rdata,                    // Read data, cycle after rd
  output logic irq,                             // Level interrupt
  input wire sdc_pkg::sdc_motion_t motion,      // Motion status from positioner
  input wire logic [EMF_W-1:0] emf_mv,          // Measured back-emf
  input wire logic [POS_W-1:0] int_position,    // Internal position counter
  input wire logic switch_input_pin,            // Switch input level
  input wire logic [14:0] otp_rdata,            // Stored OTP parameters
  output logic otp_we,                          // OTP write pulse
  output logic [14:0] otp_wdata,                // OTP write data
  output logic hard_stop,                       // Internal hard stop pulse
  output logic position_enable,                 // Positioning commands accepted
  output logic switch_analog_en,                // Pin turned to analog output
  output logic switch_state,                    // Sampled switch state
  output logic emf_sample                       // Back-emf sample strobe
);
  import sdc_pkg::*;

  sdc_param_t param_r, param_nxt;
  logic [5:0] flags_r, flags_nxt;
  logic [POS_W-1:0] act_pos_r, act_pos_nxt;
  logic [NEV-1:0] ist_r, ist_nxt, imask_r, imask_nxt;
  logic [DELAY_CYC_W-1:0] dcnt_r, dcnt_nxt;
  logic dly_run_r, dly_run_nxt;
  logic [2:0] fs_cnt_r, fs_cnt_nxt;
  logic armed_r, armed_nxt;
  logic [EMF_W-1:0] avg_r, avg_nxt;
  logic sw_r, sw_nxt;
  logic [31:0] rdata_nxt;
  logic otp_we_nxt, hard_stop_nxt, sample_nxt, pos_en_r, pos_en_nxt;

  logic cmd_wr, full_rd, short_rd;
  logic detect_en, sample_go, abs_hit, dlo_hit, dhi_hit, stall_ev;
  logic [EMF_W-1:0] abs_lvl, del_lvl;
  logic [DELAY_CYC_W-1:0] dly_cycles;
  logic [NEV-1:0] events;

  // Cycle count of the sample delay: truncation is fine, table is least time
  function automatic logic [DELAY_CYC_W-1:0] delay_cyc(input logic [2:0] sel);
    int unsigned c;
    c = (DELAY_US[sel] * (CLK_HZ / 1000000));
    return c[DELAY_CYC_W-1:0];
  endfunction

  assign cmd_wr = wr && (addr == ADDR_CMD);
  assign full_rd = cmd_wr && (wdata[2:0] == CMD_READ_FULL);
  assign short_rd = cmd_wr && (wdata[2:0] == CMD_READ_SHORT);
  // Zero codes on both fields turn detection off altogether
  assign detect_en = (param_r.absolute_threshold != 4'h0)
                     || (param_r.delta_threshold != 4'h0);
  // Linear level per code; code zero yields no level
  assign abs_lvl = EMF_W'(param_r.absolute_threshold * ABS_STEP_MV);
  assign del_lvl = EMF_W'(param_r.delta_threshold * DEL_STEP_MV);
  assign dly_cycles = delay_cyc(param_r.sample_delay_select);
  assign sample_go = dly_run_r && (dcnt_r == '0);
  // Evaluate only at cruise speed, after activation delay, duty gated
  assign abs_hit = sample_go && armed_r && motion.at_max_velocity
                   && (param_r.absolute_threshold != 4'h0)
                   && (emf_mv < abs_lvl)
                   && (!motion.full_duty || param_r.full_duty_detect_enable);
  assign dlo_hit = sample_go && armed_r && motion.at_max_velocity
                   && (param_r.delta_threshold != 4'h0)
                   && ({1'b0, emf_mv} + {1'b0, del_lvl} < {1'b0, avg_r})
                   && (!motion.full_duty || param_r.full_duty_detect_enable);
  assign dhi_hit = sample_go && armed_r && motion.at_max_velocity
                   && (param_r.delta_threshold != 4'h0)
                   && ({1'b0, emf_mv} > {1'b0, avg_r} + {1'b0, del_lvl})
                   && (!motion.full_duty || param_r.full_duty_detect_enable);
  assign stall_ev = abs_hit || dlo_hit || dhi_hit;
  assign events = {full_rd || short_rd, sample_go, stall_ev};

  always_comb
  begin
    param_nxt = param_r;
    flags_nxt = flags_r;
    act_pos_nxt = act_pos_r;
    ist_nxt = ist_r;
    imask_nxt = imask_r;
    dcnt_nxt = dcnt_r;
    dly_run_nxt = dly_run_r;
    fs_cnt_nxt = fs_cnt_r;
    armed_nxt = armed_r;
    avg_nxt = avg_r;
    sw_nxt = sw_r;
    otp_we_nxt = 1'b0;
    hard_stop_nxt = 1'b0;
    sample_nxt = sample_go;
    pos_en_nxt = pos_en_r;
    rdata_nxt = 32'h0000_0000;
    // Register writes
    if (wr)
    begin
      case (addr)
        ADDR_PARAM: param_nxt = wdata[14:0];
        ADDR_IRQ_MASK: imask_nxt = wdata[NEV-1:0];
        ADDR_IRQ_STAT: ist_nxt = ist_r & ~wdata[NEV-1:0];
        default: ;
      endcase
    end
    if (cmd_wr)
    begin
      case (wdata[2:0])
        CMD_WRITE_PARAMS:
        begin
          param_nxt.absolute_threshold = wdata[ABS_LSB+8 +: 4];
          param_nxt.delta_threshold = wdata[DEL_LSB+8 +: 4];
        end
        CMD_WRITE_OTP:
          otp_we_nxt = 1'b1;
        CMD_OBSERVE:
          flags_nxt[FL_QUAL] = 1'b1;
        default: ;
      endcase
    end
    // Flag clear, then sets below win over the clear
    if (full_rd)
    begin
      flags_nxt[4:0] = 5'h00;
      pos_en_nxt = 1'b1;
    end
    if (short_rd)
    begin
      flags_nxt[FL_STEPLOSS] = 1'b0;
      pos_en_nxt = 1'b1;
    end
    if (abs_hit)
      flags_nxt[FL_ABS] = 1'b1;
    if (dlo_hit)
      flags_nxt[FL_DLO] = 1'b1;
    if (dhi_hit)
      flags_nxt[FL_DHI] = 1'b1;
    flags_nxt[FL_STALL] = flags_nxt[FL_ABS] | flags_nxt[FL_DLO] | flags_nxt[FL_DHI];
    if (stall_ev && motion.positioning)
    begin
      hard_stop_nxt = 1'b1;
      flags_nxt[FL_STEPLOSS] = 1'b1;
      act_pos_nxt = int_position;
      pos_en_nxt = 1'b0;
    end
    else if (pos_en_r)
      act_pos_nxt = int_position;
    // Sample delay timer
    if (motion.zero_cross)
    begin
      dly_run_nxt = 1'b1;
      dcnt_nxt = dly_cycles;
    end
    else if (dly_run_r)
    begin
      if (dcnt_r == '0)
        dly_run_nxt = 1'b0;
      else
        dcnt_nxt = dcnt_r - 1'b1;
    end
    if (sample_go)
      avg_nxt = EMF_W'(({1'b0, avg_r} + {1'b0, emf_mv}) >> 1);
    // Activation: full steps counted once cruise begins
    if (!motion.at_max_velocity || !detect_en)
    begin
      armed_nxt = 1'b0;
      fs_cnt_nxt = 3'h0;
    end
    else if (!armed_r)
    begin
      if (fs_cnt_r == param_r.fullstep_activation_delay)
        armed_nxt = 1'b1;
      else if (motion.full_step)
        fs_cnt_nxt = fs_cnt_r + 3'h1;
    end
    // Sampling of the pin stops while observing back-emf
    if (!flags_r[FL_QUAL])
      sw_nxt = switch_input_pin;
    ist_nxt = ist_nxt | events;
    if (rd)
    begin
      case (addr)
        ADDR_PARAM: rdata_nxt = {17'h00000, param_r};
        ADDR_FLAGS: rdata_nxt = {26'h0000000, flags_r};
        ADDR_IRQ_STAT: rdata_nxt = {29'h00000000, ist_r};
        ADDR_IRQ_MASK: rdata_nxt = {29'h00000000, imask_r};
        ADDR_POS: rdata_nxt = {{(32-POS_W){1'b0}}, act_pos_r};
        ADDR_OTP: rdata_nxt = {17'h00000, otp_rdata};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      flags_r <= 6'h00;
      act_pos_r <= '0;
      ist_r <= '0;
      imask_r <= '0;
      dcnt_r <= '0;
      dly_run_r <= 1'b0;
      fs_cnt_r <= 3'h0;
      armed_r <= 1'b0;
      avg_r <= '0;
      sw_r <= 1'b0;
      rdata <= 32'h0000_0000;
      otp_we <= 1'b0;
      hard_stop <= 1'b0;
      emf_sample <= 1'b0;
      pos_en_r <= 1'b1;
    end
    else
    begin
      flags_r <= flags_nxt;
      act_pos_r <= act_pos_nxt;
      ist_r <= ist_nxt;
      imask_r <= imask_nxt;
      dcnt_r <= dcnt_nxt;
      dly_run_r <= dly_run_nxt;
      fs_cnt_r <= fs_cnt_nxt;
      armed_r <= armed_nxt;
      avg_r <= avg_nxt;
      sw_r <= sw_nxt;
      rdata <= rdata_nxt;
      otp_we <= otp_we_nxt;
      hard_stop <= hard_stop_nxt;
      emf_sample <= sample_nxt;
      pos_en_r <= pos_en_nxt;
    end
  end

  // Working copy reloads from OTP on every power-on reset pulse, unless rst is high in the same cycle
  always_ff @(posedge mclk)
  begin
    if (rst)
      param_r <= PARAM_RST;
    else if (por)
      param_r <= otp_rdata;
    else
      param_r <= param_nxt;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      otp_wdata <= 15'h0000;
    else if (otp_we_nxt)
      otp_wdata <= wdata[8 +: 15];
  end

  assign irq = |(ist_r & imask_r);
  assign position_enable = pos_en_r;
  assign switch_analog_en = flags_r[FL_QUAL];
  assign switch_state = sw_r;
endmodule

// ===== sdc_pkg.sv
// Purpose: Constants and carrier types for the stall detection configuration block
// Assumes: 40 MHz mclk, synchronous active-high reset
// Notes: Register map offsets are word addresses on the plain register port
package sdc_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam logic [3:0] ADDR_CMD = 4'h0;
  localparam logic [3:0] ADDR_PARAM = 4'h1;
  localparam logic [3:0] ADDR_FLAGS = 4'h2;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h3;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h4;
  localparam logic [3:0] ADDR_POS = 4'h5;
  localparam logic [3:0] ADDR_OTP = 4'h6;
  // Command codes written to ADDR_CMD
  localparam logic [2:0] CMD_READ_FULL = 3'h1;
  localparam logic [2:0] CMD_READ_SHORT = 3'h2;
  localparam logic [2:0] CMD_WRITE_PARAMS = 3'h3;
  localparam logic [2:0] CMD_WRITE_OTP = 3'h4;
  localparam logic [2:0] CMD_OBSERVE = 3'h5;
  // Param word fields
  localparam int ABS_LSB = 0;
  localparam int DEL_LSB = 4;
  localparam int SDS_LSB = 8;
  localparam int FAD_LSB = 11;
  localparam int FDE_BIT = 14;
  localparam logic [14:0] PARAM_RST = 15'h0000;
  // Flag word bits
  localparam int FL_STEPLOSS = 0;
  localparam int FL_STALL = 1;
  localparam int FL_ABS = 2;
  localparam int FL_DLO = 3;
  localparam int FL_DHI = 4;
  localparam int FL_QUAL = 5;
  // Interrupt event bits
  localparam int EV_STALL = 0;
  localparam int EV_SAMPLE = 1;
  localparam int EV_CLEAR = 2;
  localparam int NEV = 3;
  // Sample delay table, microseconds
  localparam int unsigned DELAY_US [8] = '{87, 130, 174, 217, 261, 304, 348, 391};
  localparam int unsigned DELAY_CYC_W = 14;
  localparam int unsigned ABS_STEP_MV = 500;
  localparam int unsigned DEL_STEP_MV = 250;

  typedef struct packed {
    logic full_duty_detect_enable;
    logic [2:0] fullstep_activation_delay;
    logic [2:0] sample_delay_select;
    logic [3:0] delta_threshold;
    logic [3:0] absolute_threshold;
  } sdc_param_t;

  typedef struct packed {
    logic at_max_velocity;
    logic positioning;
    logic full_step;
    logic full_duty;
    logic zero_cross;
  } sdc_motion_t;
endpackage

// ===== sdc_top_sva.sv
// Purpose: Port assertions for the stall detection configuration block
// Assumes: One mclk domain, rst synchronous and active high
// Notes: Sample delay bounded by the shortest and longest delay codes
`timescale 1ns/1ps
module sdc_top_sva
  import sdc_pkg::*;
(
  input wire logic mclk, // Clock
  input wire logic rst, // Reset
  input wire logic [3:0] addr, // Address
  input wire logic [31:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire sdc_pkg::sdc_motion_t motion, // Motion status
  input wire logic otp_we, // OTP write pulse
  input wire logic [14:0] otp_wdata, // OTP write data
  input wire logic hard_stop, // Hard stop pulse
  input wire logic position_enable, // Positioning allowed
  input wire logic switch_analog_en, // Qualification mode
  input wire logic switch_state, // Sampled switch
  input wire logic emf_sample // Sample strobe
);
  logic [15:0] since_zc_r;
  logic [15:0] since_zc_nxt;
  logic cmd_wr;
  logic clr_cmd;
  assign cmd_wr = wr && addr == ADDR_CMD;
  assign clr_cmd = cmd_wr && (wdata[2:0] == CMD_READ_FULL || wdata[2:0] == CMD_READ_SHORT);
  // Saturates so a stale crossing never wraps into the legal window
  always_comb
    since_zc_nxt = motion.zero_cross ? 16'h0 : since_zc_r + {15'h0, since_zc_r != 16'hffff};
  always_ff @(posedge mclk)
    since_zc_r <= rst ? 16'hffff : since_zc_nxt;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  otp_pulse_a: assert property (
    cmd_wr && wdata[2:0] == CMD_WRITE_OTP |=> otp_we && otp_wdata == $past(wdata[22:8]))
    else $error("otp write missing");
  qual_enter_a: assert property (
    cmd_wr && wdata[2:0] == CMD_OBSERVE |-> ##[1:2] switch_analog_en)
    else $error("observe mode not entered");
  qual_hold_a: assert property (switch_analog_en |=> switch_analog_en)
    else $error("observe mode left");
  switch_frozen_a: assert property (switch_analog_en [*3] |=> $stable(switch_state))
    else $error("switch sampled in observe mode");
  pos_resume_a: assert property (clr_cmd && !hard_stop |-> ##[1:2] position_enable)
    else $error("positioning not resumed");
  stop_lock_a: assert property (hard_stop |-> ##[0:1] !position_enable)
    else $error("positioning not blocked");
  lock_hold_a: assert property (!position_enable && !clr_cmd |=> !position_enable)
    else $error("positioning released early");
  stop_gate_a: assert property (
    hard_stop |-> $past(motion.positioning) && $past(motion.at_max_velocity))
    else $error("hard stop without cause");
  emf_delay_a: assert property (
    emf_sample |-> since_zc_r >= 16'd3479 && since_zc_r <= 16'd15645)
    else $error("sample delay out of range");
  cover property (hard_stop);
  cover property ($rose(switch_analog_en));
  cover property (otp_we);
endmodule
bind sdc_top sdc_top_sva chk_i (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata),
  .wr(wr), .motion(motion), .otp_we(otp_we), .otp_wdata(otp_wdata), .hard_stop(hard_stop),
  .position_enable(position_enable), .switch_analog_en(switch_analog_en),
  .switch_state(switch_state), .emf_sample(emf_sample));

// ===== sdc_bus_master.sv
// Purpose: Bus master model issuing command and status accesses
// Assumes: Caller enters just after a rising mclk edge
// Notes: One idle edge after each access keeps strobes single-driven
`timescale 1ns/1ps
module sdc_bus_master
(
  input wire logic mclk, // Clock
  output logic [3:0] addr = 4'h0, // Address
  output logic [31:0] wdata = 32'h0, // Write data
  output logic wr = 1'b0, // Write strobe
  output logic rd = 1'b0 // Read strobe
);
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge mclk);
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge mclk);
  endtask
endmodule

// ===== stall_detection_config_tb_top.sv
// Purpose: Self-checking bench for the stall detection configuration block
// Assumes: Read data compared at the falling edge after the read
// Notes: Each zero-crossing run waits out the longest delay
`timescale 1ns/1ps
module stall_detection_config_tb_top;
  import sdc_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic por = 1'b0;
  logic [3:0] addr;
  logic [31:0] wdata, rdata, v;
  logic wr, rd, irq, otp_we, hard_stop, position_enable;
  logic switch_analog_en, switch_state, emf_sample;
  logic [14:0] otp_wdata;
  logic [14:0] otp_rdata = 15'h0;
  sdc_motion_t motion = '0;
  logic [13:0] emf_mv = 14'h0;
  logic [15:0] int_position = 16'h0;
  logic switch_input_pin = 1'b0;
  logic rd_d = 1'b0;
  logic [31:0] seed = 32'hfce8;
  logic [31:0] exp_q[$];
  logic [14:0] cfg[3] = '{15'h1000, 15'h100f, 15'h500f};
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  int stops, first;
  sdc_bus_master m (.mclk(mclk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
  sdc_top uut (.mclk(mclk), .rst(rst), .por(por), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .irq(irq), .motion(motion), .emf_mv(emf_mv),
    .int_position(int_position), .switch_input_pin(switch_input_pin), .otp_rdata(otp_rdata),
    .otp_we(otp_we), .otp_wdata(otp_wdata), .hard_stop(hard_stop),
    .position_enable(position_enable), .switch_analog_en(switch_analog_en),
    .switch_state(switch_state), .emf_sample(emf_sample));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic conclude();
    if (error_cnt == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    m.acc(1'b0, a, 32'h0);
  endtask
  task automatic cmd(input logic [2:0] c, input logic [14:0] p);
    m.acc(1'b1, ADDR_CMD, {9'h0, p, 5'h0, c});
  endtask
  // Arms with two full steps, then one crossing; counts every stop seen
  task automatic run_zc();
    stops = 0;
    first = 0;
    repeat (2)
    begin
      motion.full_step <= 1'b1;
      @(posedge mclk);
      motion.full_step <= 1'b0;
      @(posedge mclk);
    end
    motion.zero_cross <= 1'b1;
    @(posedge mclk);
    motion.zero_cross <= 1'b0;
    for (int i = 1; i < 16000; i++)
    begin
      @(negedge mclk);
      if (hard_stop === 1'b1 && stops++ == 0)
        first = i;
    end
    @(posedge mclk);
  endtask
  initial
    forever #12.5 mclk = ~mclk;
  always @(posedge mclk)
  begin
    rd_d <= rd;
    cyc++;
    if (cyc == 60000)
    begin
      error_cnt++;
      conclude();
    end
  end
  always @(negedge mclk)
    if (rd_d)
      chk(rdata, exp_q.pop_front());
  initial
  begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rchk(4'hf, 32'h0);
    v = rnd();
    cmd(CMD_WRITE_PARAMS, v[14:0]);
    rchk(ADDR_PARAM, {24'h0, v[7:0]});
    cmd(CMD_WRITE_OTP, v[30:16]);
    chk(otp_wdata, v[30:16]);
    v = rnd();
    otp_rdata <= v[14:0];
    por <= 1'b1;
    @(posedge mclk);
    por <= 1'b0;
    @(posedge mclk);
    rchk(ADDR_PARAM, {17'h0, v[14:0]});
    rchk(ADDR_OTP, {17'h0, v[14:0]});
    cmd(CMD_READ_FULL, 15'h0);
    m.acc(1'b1, ADDR_IRQ_MASK, 32'h1);
    v = rnd();
    emf_mv <= {2'h0, v[11:0]};
    int_position <= v[31:16];
    motion.at_max_velocity <= 1'b1;
    motion.positioning <= 1'b1;
    motion.full_duty <= 1'b1;
    for (int k = 0; k < 3; k++)
    begin
      m.acc(1'b1, ADDR_PARAM, {17'h0, cfg[k]});
      run_zc();
      chk(stops, k / 2);
    end
    chk(first >= 3480 && first <= 3490, 1);
    motion.positioning <= 1'b0;
    // New counter value must stay hidden until a status read
    int_position <= ~v[31:16];
    chk(position_enable, 1'b0);
    chk(irq, 1'b1);
    rchk(ADDR_FLAGS, 32'h7);
    rchk(ADDR_POS, {16'h0, v[31:16]});
    cmd(CMD_READ_SHORT, 15'h0);
    rchk(ADDR_FLAGS, 32'h6);
    chk(position_enable, 1'b1);
    rchk(ADDR_POS, {16'h0, ~v[31:16]});
    cmd(CMD_READ_FULL, 15'h0);
    rchk(ADDR_FLAGS, 32'h0);
    rchk(ADDR_IRQ_STAT, 32'h7);
    m.acc(1'b1, ADDR_IRQ_MASK, 32'h0);
    chk(irq, 1'b0);
    m.acc(1'b1, ADDR_IRQ_STAT, 32'h7);
    rchk(ADDR_IRQ_STAT, 32'h0);
    switch_input_pin <= 1'b1;
    repeat (4) @(posedge mclk);
    chk(switch_state, 1'b1);
    cmd(CMD_OBSERVE, 15'h0);
    chk(switch_analog_en, 1'b1);
    switch_input_pin <= 1'b0;
    repeat (4) @(posedge mclk);
    chk(switch_state, 1'b1);
    cmd(CMD_READ_FULL, 15'h0);
    rchk(ADDR_FLAGS, 32'h20);
    chk(switch_analog_en, 1'b1);
    conclude();
  end
endmodule
